// ===== clkctl.sv
/*
 Clock control block: glitch-free system clock divider with timed unlock,
 USB PLL control/status and regulator-off control, on an APB slave.
 Assumes fuse and PLL lock inputs come from outside the pclk domain.
*/
// Functional notes
// - Core, flash and I/O clock enables all follow one divider select.
// - Divided clock changes only at period boundaries, never a runt pulse.
// - Switch waits for old period end, so no faster intermediate period.
// - New rate begins at the next old boundary, first new edge after T2.
// - Unlock bit sets only when written bits 6 to 0 are zero.
// - Unlock clears after four divided clock periods or when select is written.
// - Rewriting unlock while open neither extends nor clears the window.
// - Divider control bits 6 to 4 read as zero.
// - Select resets to 0000, or 0011 when divide-by-eight fuse programmed.
// - Any select value is accepted whatever the fuse says.
// - Code n in 0..8 divides by 2 to the n; codes above reserved.
// - PLL multiplies its 8 MHz reference by six to 48 MHz.
// - PLL input divider code 000 divides by 1, 001 by 2.
// - PLL run bit starts PLL and the RC reference when needed.
// - PLL run reads one while PLL is the system clock source.
// - Lock flag sets once PLL locks, about 1 ms after enabling.
// - PLL control register bits 7 to 5 read as zero.
// - Writing one to regulator off disables the internal regulator.
// - Regulator off clears to zero on every reset.
`timescale 1ns/1ps
`default_nettype none
module clkctl #(
    parameter int LOCK_CYCLES = clkctl_pkg::PLL_LOCK_CYCLES
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        divide_by_eight_fuse,
    input  wire logic        pll_lock_in,
    output logic             sys_clk_en,
    output logic             pll_enable,
    output logic             rc_osc_enable,
    output logic      [2:0]  pll_input_divider_out,
    output logic      [2:0]  pll_multiply,
    output logic             regulator_disable
);
    logic        fuse_s1_reg, fuse_s2_reg, lock_s1_reg, lock_s2_reg;
    logic [3:0]  divider_select_reg;
    logic [3:0]  active_select_reg;
    logic [8:0]  div_count_reg;
    logic        unlock_reg;
    logic [2:0]  unlock_count_reg;
    logic [1:0]  fuse_wait_reg;
    logic [2:0]  pll_input_divider_reg;
    logic        pll_run_reg;
    logic        pll_locked_flag_reg;
    logic [31:0] lock_count_reg;
    logic        regulator_off_reg;
    logic        source_pll_reg;
    logic        access;
    logic        wr;
    logic        boundary;
    logic        sel_wr;
    logic        unlock_wr;
    logic        pll_run_eff;
    logic [8:0]  terminal;
    logic [31:0] rdata;
    logic        hit;

    assign access    = psel && penable;
    assign wr        = access && pwrite;
    assign sel_wr    = wr && paddr == clkctl_pkg::SYSCLK_DIVIDER_CTRL_OFS
                       && !pwdata[clkctl_pkg::UNLOCK_BIT] && unlock_reg;
    assign unlock_wr = wr && paddr == clkctl_pkg::SYSCLK_DIVIDER_CTRL_OFS
                       && pwdata[7:0] == 8'h80;
    assign pll_run_eff = pll_run_reg || source_pll_reg;
    // Terminal count 2^n - 1, reserved codes held at the full 9-bit count (divide by 512)
    assign terminal  = (active_select_reg > clkctl_pkg::SELECT_MAX)
                       ? 9'h1ff : 9'((10'h1 << active_select_reg) - 10'h1);
    assign boundary  = div_count_reg == terminal;

    // Fuse and lock cross from outside
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fuse_s1_reg <= 1'b0;
            fuse_s2_reg <= 1'b0;
            lock_s1_reg <= 1'b0;
            lock_s2_reg <= 1'b0;
        end else begin
            fuse_s1_reg <= divide_by_eight_fuse;
            fuse_s2_reg <= fuse_s1_reg;
            lock_s1_reg <= pll_lock_in;
            lock_s2_reg <= lock_s1_reg;
        end
    end

    // Select register; fuse caught once the synchroniser has filled after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            divider_select_reg <= clkctl_pkg::SELECT_RESET_FUSE_OFF;
            fuse_wait_reg      <= 2'h0;
        end else if (fuse_wait_reg != 2'h3) begin
            fuse_wait_reg      <= fuse_wait_reg + 2'h1;
            if (fuse_wait_reg == 2'h2) begin
                divider_select_reg <= fuse_s2_reg ? clkctl_pkg::SELECT_RESET_FUSE_ON
                                                  : clkctl_pkg::SELECT_RESET_FUSE_OFF;
            end
        end else if (sel_wr) begin
            divider_select_reg <= pwdata[clkctl_pkg::SELECT_MSB:0];
        end
    end

    // Divider counter; new setting adopted only at an old period end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_count_reg     <= 9'h000;
            active_select_reg <= clkctl_pkg::SELECT_RESET_FUSE_OFF;
        end else if (boundary) begin
            div_count_reg     <= 9'h000;
            active_select_reg <= divider_select_reg;
        end else begin
            div_count_reg     <= div_count_reg + 9'h001;
        end
    end

    // One enable pulse per divided period drives core, flash and I/O
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_clk_en <= 1'b0;
        end else begin
            sys_clk_en <= boundary;
        end
    end

    // Unlock window
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unlock_reg       <= 1'b0;
            unlock_count_reg <= 3'h0;
        end else if (sel_wr) begin
            unlock_reg       <= 1'b0;
        end else if (unlock_wr && !unlock_reg) begin
            unlock_reg       <= 1'b1;
            unlock_count_reg <= 3'h0;
        end else if (unlock_reg && boundary) begin
            if (unlock_count_reg == clkctl_pkg::UNLOCK_WINDOW_CYCLES - 3'h1) begin
                unlock_reg <= 1'b0;
            end
            unlock_count_reg <= unlock_count_reg + 3'h1;
        end
    end

    // PLL control
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_run_reg           <= 1'b0;
            pll_input_divider_reg <= clkctl_pkg::PLL_DIV_BY1;
            source_pll_reg        <= 1'b0;
        end else if (wr && paddr == clkctl_pkg::PLL_CTRL_STATUS_OFS) begin
            pll_run_reg <= pwdata[clkctl_pkg::PLL_RUN_BIT];
            if (pwdata[4:2] == clkctl_pkg::PLL_DIV_BY1
                || pwdata[4:2] == clkctl_pkg::PLL_DIV_BY2) begin
                pll_input_divider_reg <= pwdata[4:2];
            end
        end else if (wr && paddr == clkctl_pkg::SOURCE_CTRL_OFS) begin
            source_pll_reg <= pwdata[clkctl_pkg::SOURCE_PLL_BIT];
        end
    end

    // Lock flag after the lock time and a locked indication
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_count_reg      <= 32'h0;
            pll_locked_flag_reg <= 1'b0;
        end else if (!pll_run_eff) begin
            lock_count_reg      <= 32'h0;
            pll_locked_flag_reg <= 1'b0;
        end else if (lock_count_reg < 32'(LOCK_CYCLES)) begin
            lock_count_reg      <= lock_count_reg + 32'h1;
        end else begin
            pll_locked_flag_reg <= lock_s2_reg;
        end
    end

    // Regulator control
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            regulator_off_reg <= 1'b0;
        end else if (wr && paddr == clkctl_pkg::REGULATOR_CTRL_OFS) begin
            regulator_off_reg <= pwdata[clkctl_pkg::REGULATOR_OFF_BIT];
        end
    end

    // Outputs to analog side
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_enable            <= 1'b0;
            rc_osc_enable         <= 1'b0;
            pll_input_divider_out <= clkctl_pkg::PLL_DIV_BY1;
            pll_multiply          <= clkctl_pkg::PLL_MULTIPLY;
            regulator_disable     <= 1'b0;
        end else begin
            pll_enable            <= pll_run_eff;
            rc_osc_enable         <= pll_run_eff;
            pll_input_divider_out <= pll_input_divider_reg;
            pll_multiply          <= clkctl_pkg::PLL_MULTIPLY;
            regulator_disable     <= regulator_off_reg;
        end
    end

    // Read decode
    always_comb begin
        rdata = 32'h0;
        hit   = 1'b1;
        if (paddr == clkctl_pkg::SYSCLK_DIVIDER_CTRL_OFS) begin
            rdata = {24'h0, unlock_reg, 3'h0, divider_select_reg};
        end else if (paddr == clkctl_pkg::PLL_CTRL_STATUS_OFS) begin
            rdata = {27'h0, pll_input_divider_reg, pll_run_eff,
                     pll_locked_flag_reg};
        end else if (paddr == clkctl_pkg::REGULATOR_CTRL_OFS) begin
            rdata = {31'h0, regulator_off_reg};
        end else if (paddr == clkctl_pkg::SOURCE_CTRL_OFS) begin
            rdata = {31'h0, source_pll_reg};
        end else begin
            hit = 1'b0;
        end
    end

    // APB answer: zero wait states, registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            prdata  <= (psel && !penable && !pwrite) ? rdata : 32'h0;
            pslverr <= psel && !penable && !hit;
        end
    end
endmodule // clkctl
`default_nettype wire

// ===== clkctl_pkg.sv
/*
 Constants for the clock control block: APB offsets, field positions,
 reset values and timing counts. Assumes a 200 MHz pclk.
*/
package clkctl_pkg;
    // Byte offsets on APB (PLL offset as printed, others placed below it)
    localparam logic [7:0] PLL_CTRL_STATUS_INDEX    = 8'h29;
    localparam logic [7:0] PLL_CTRL_STATUS_OFS      = 8'(PLL_CTRL_STATUS_INDEX * 4);
    localparam logic [7:0] SYSCLK_DIVIDER_CTRL_OFS  = 8'h00;
    localparam logic [7:0] REGULATOR_CTRL_OFS       = 8'h04;
    localparam logic [7:0] SOURCE_CTRL_OFS          = 8'h08;
    // Divider control fields
    localparam int         UNLOCK_BIT               = 7;
    localparam int         SELECT_MSB               = 3;
    localparam logic [3:0] SELECT_RESET_FUSE_OFF    = 4'h0;
    localparam logic [3:0] SELECT_RESET_FUSE_ON     = 4'h3;
    localparam logic [3:0] SELECT_MAX               = 4'h8;
    localparam logic [2:0] UNLOCK_WINDOW_CYCLES     = 3'h4;
    // PLL control fields
    localparam int         PLL_DIV_LSB              = 2;
    localparam int         PLL_RUN_BIT              = 1;
    localparam int         PLL_LOCK_BIT             = 0;
    localparam logic [2:0] PLL_DIV_BY1              = 3'h0;
    localparam logic [2:0] PLL_DIV_BY2              = 3'h1;
    localparam logic [2:0] PLL_MULTIPLY             = 3'h6;
    // Lock time in microseconds and the cycle count derived from it
    localparam int         PLL_LOCK_TIME_US         = 1000;
    localparam int         PCLK_MHZ                 = 200;
    localparam int         PLL_LOCK_CYCLES          = PLL_LOCK_TIME_US * PCLK_MHZ;
    localparam int         REGULATOR_OFF_BIT        = 0;
    localparam int         SOURCE_PLL_BIT           = 0;
endpackage

// ===== clkctl_props.sv
/*
 Checker for the clock control block: APB timing and register effects.
 Assumes it is bound to clkctl ports other than the fuse, lock input and sys_clk_en.
*/
`timescale 1ns/1ps
`default_nettype none
module clkctl_props #(parameter int LOCK_CYCLES = 20) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        pll_enable,
    input wire logic        rc_osc_enable,
    input wire logic [2:0]  pll_input_divider_out,
    input wire logic [2:0]  pll_multiply,
    input wire logic        regulator_disable
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_after_setup: assert property (psel && !penable |=> pready && penable)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready too long");
    a_mult_six: assert property (pll_multiply == 3'h6) else $error("multiplier not six");
    a_osc_with_pll: assert property (pll_enable == rc_osc_enable)
        else $error("oscillator not with pll");
    a_pll_div_legal: assert property (pll_input_divider_out <= 3'h1)
        else $error("reserved pll divider");
    a_reg_off_write: assert property (psel && penable && pwrite &&
        paddr == clkctl_pkg::REGULATOR_CTRL_OFS |-> ##2 regulator_disable == $past(pwdata[0], 2))
        else $error("regulator bit wrong");
    a_div_res_zero: assert property (pready && !pwrite &&
        paddr == clkctl_pkg::SYSCLK_DIVIDER_CTRL_OFS |-> prdata[6:4] == 3'h0)
        else $error("divider reserved bits set");
    a_pll_res_zero: assert property (pready && !pwrite &&
        paddr == clkctl_pkg::PLL_CTRL_STATUS_OFS |-> prdata[7:5] == 3'h0 &&
        (!prdata[0] || pll_enable)) else $error("pll status bits wrong");
endmodule // clkctl_props
bind clkctl clkctl_props #(.LOCK_CYCLES(LOCK_CYCLES)) props_u (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pll_enable,
    .rc_osc_enable, .pll_input_divider_out, .pll_multiply, .regulator_disable);
`default_nettype wire

// ===== test_clkctl.sv
/*
 Self-checking bench for the clock control block over APB.
 Assumes clkctl_pkg and the checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module test_clkctl;
    localparam int LOCK = 20;
    localparam logic [7:0] DIV = clkctl_pkg::SYSCLK_DIVIDER_CTRL_OFS;
    localparam logic [7:0] PLL = clkctl_pkg::PLL_CTRL_STATUS_OFS;
    localparam logic [7:0] REG = clkctl_pkg::REGULATOR_CTRL_OFS;
    logic        pclk, presetn, psel, penable, pwrite, fuse, lock_in, pready, pslverr, err;
    logic        sys_clk_en, pll_enable, regulator_disable;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0]  pll_input_divider_out, pll_multiply;
    int          num_errors = 0, checked = 0, cycles = 0, g;
    clkctl #(.LOCK_CYCLES(LOCK)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .divide_by_eight_fuse(fuse), .pll_lock_in(lock_in),
        .sys_clk_en, .pll_enable, .rc_osc_enable(), .pll_input_divider_out, .pll_multiply,
        .regulator_disable);
    initial begin
        pclk = 0;
        forever #2.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 8000) begin
            num_errors++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("checked %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk) penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
        @(posedge pclk);
    endtask
    task automatic do_reset(input logic f);
        fuse <= f;
        presetn <= 0;
        repeat (6) @(posedge pclk);
        presetn <= 1;
        repeat (4) @(posedge pclk);
    endtask
    task automatic gap();
        do @(posedge pclk); while (sys_clk_en !== 1'b1);
        g = 0;
        do begin @(posedge pclk); g++; end while (sys_clk_en !== 1'b1 && g < 600);
    endtask
    task automatic t_unlock();
        apb(1, DIV, 32'h81); apb(0, DIV, 0); `CHK(rd, 32'h0)
        apb(1, DIV, 32'h2); apb(0, DIV, 0); `CHK(rd, 32'h0)
        apb(1, DIV, 32'h80); apb(1, DIV, 32'h2); apb(0, DIV, 0); `CHK(rd, 32'h2)
        apb(1, DIV, 32'h80); repeat (20) @(posedge pclk);
        apb(1, DIV, 32'h3); apb(0, DIV, 0); `CHK(rd, 32'h2)
        $display("unlock test done");
    endtask
    task automatic t_codes();
        for (int n = 0; n <= 8; n++) begin
            apb(1, DIV, 32'h80); apb(1, DIV, 32'h70 | n); apb(0, DIV, 0);
            `CHK(rd, 32'(n))
            gap(); gap(); `CHK(g, 1 << n)
        end
        $display("codes test done");
    endtask
    task automatic t_pll();
        apb(1, PLL, 32'he6); apb(0, PLL, 0); `CHK(rd, 32'h6)
        `CHK(pll_input_divider_out, 3'h1)
        `CHK(pll_enable, 1'b1)
        apb(1, PLL, 32'h0a); apb(0, PLL, 0); `CHK(rd, 32'h6)
        lock_in <= 1; repeat (LOCK + 10) @(posedge pclk);
        apb(0, PLL, 0); `CHK(rd, 32'h7)
        apb(1, PLL, 32'h0); @(posedge pclk);
        `CHK(pll_enable, 1'b0)
        `CHK(pll_multiply, 3'h6)
        $display("pll test done");
    endtask
    task automatic t_reg();
        apb(1, REG, 32'h1); @(posedge pclk);
        `CHK(regulator_disable, 1'b1)
        apb(0, 8'h40, 0); `CHK(err, 1'b1)
        `CHK(rd, 32'h0)
        do_reset(1); apb(0, REG, 0); `CHK(rd, 32'h0)
        apb(0, DIV, 0); `CHK(rd, 32'h3)
        gap(); `CHK(g, 8)
        $display("reset test done");
    endtask
    initial begin
        psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; lock_in = 0;
        do_reset(0);
        apb(0, DIV, 0); `CHK(rd, 32'h0)
        t_unlock();
        t_codes();
        t_pll();
        t_reg();
        give_verdict();
    end
endmodule // test_clkctl
`default_nettype wire
